// ==== port_select_freq_counter_regs.sv ====
// i2c slave holding the port steering, pin status, pixel frequency meter
// and far-end capability registers of a video serializer.
// assumes scl/sda/pin inputs are asynchronous; back-channel inputs are on clk.
`timescale 1ns/1ps
`include "psfc_map.svh"
module port_select_freq_counter_regs
  import psfc_pkg::*;
(
  input  wire logic        clk,                    // 25 MHz oscillator clock
  input  wire logic        nrst,                   // async reset, active low
  input  wire logic        scl_i,                  // i2c clock pin
  input  wire logic        sda_i,                  // i2c data pin level
  output logic             sda_o,                  // i2c data drive value (low)
  output logic             sda_oe,                 // i2c data drive enable
  input  wire logic [6:0]  own_bus_address,        // 7-bit primary address strap
  input  wire logic        gp_pin_eight,           // general purpose pin eight
  input  wire logic        pin_input_mode,         // pin eight is an input
  input  wire logic        pixel_clk_pin,          // pixel clock pin
  input  wire logic [1:0]  far_lock,               // far receiver lock per port
  input  wire logic [15:0] far_caps,               // back-channel caps, port1:port0
  output logic [1:0]       freq_training_request   // send training pattern per port
);

  // ************************************************************
  // state and helpers
  // ************************************************************
  regs_s       cur;
  regs_s       nxt;
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;
  logic        hit_primary;
  logic        hit_second;
  logic        rd_port;
  logic [1:0]  wr_ports;
  logic [7:0]  rd_data;
  logic [6:0]  second_addr;

  meter_if     mtr ();

  pixel_freq_meter u_meter
  (
    .clk      (clk),
    .nrst     (nrst),
    .pclk_pin (pixel_clk_pin),
    .mtr      (mtr)
  );

  assign mtr.start    = cur.fc_start;
  assign mtr.interval = cur.fc_val;

  // ************************************************************
  // bus events
  // ************************************************************
  // only the second synchroniser stage and its delayed copy are looked at
  assign scl_rise  = cur.scl_s & ~cur.scl_p;
  assign scl_fall  = ~cur.scl_s & cur.scl_p;
  assign bus_start = cur.scl_s & cur.scl_p & cur.sda_p & ~cur.sda_s;
  assign bus_stop  = cur.scl_s & cur.scl_p & ~cur.sda_p & cur.sda_s;

  // ************************************************************
  // address match and port steering
  // ************************************************************
  assign second_addr = 7'(cur.addr_s + 7'h01);
  assign hit_primary = (cur.sh[7:1] == cur.addr_s);
  assign hit_second  = cur.steer[`BIT_SECOND_ADDR]
                       && (cur.sh[7:1] == second_addr);

  always_comb
  begin
    if (cur.steer[`BIT_SECOND_ADDR])
    begin
      // picks are ignored; the address alone names the port
      rd_port  = cur.sec_hit;
      wr_ports = {cur.sec_hit, ~cur.sec_hit};
    end
    else
    begin
      // port one wins a read when both picks are set
      rd_port  = cur.steer[`BIT_SECONDARY_PICK];
      wr_ports = {cur.steer[`BIT_SECONDARY_PICK],
                  cur.steer[`BIT_PRIMARY_PICK]};
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  always_comb
  begin
    case (cur.ptr)
      // level is reported only while the pin is configured as input
      `REG_PIN_STATUS: rd_data = {7'h00, cur.gp_s & pin_input_mode};
      `REG_PORT_STEER: rd_data = cur.steer & `STEER_WR_MASK;
      `REG_FREQ_METER: rd_data = mtr.count;
      `REG_FAR_CAPS:   rd_data = cur.caps[rd_port];
      default:         rd_data = 8'h00;
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    nxt          = cur;
    nxt.fc_start = 1'b0;
    nxt.scl_m    = scl_i;
    nxt.scl_s    = cur.scl_m;
    nxt.scl_p    = cur.scl_s;
    nxt.sda_m    = sda_i;
    nxt.sda_s    = cur.sda_m;
    nxt.sda_p    = cur.sda_s;
    nxt.gp_m     = gp_pin_eight;
    nxt.gp_s     = cur.gp_m;
    nxt.addr_m   = own_bus_address;
    nxt.addr_s   = cur.addr_m;

    // back-channel load comes first so a software write in the same
    // cycle wins over it
    for (int p = 0; p < 2; p++)
    begin
      if (far_lock[p] && !cur.caps[p][`BIT_HOLD_CAPS])
        nxt.caps[p] = (cur.caps[p] & ~`CAPS_AUTO_MASK)
                      | (far_caps[p*8 +: 8] & `CAPS_AUTO_MASK);
    end

    if (bus_start)
    begin
      nxt.st     = S_ADDR;
      nxt.bits   = 4'h0;
      nxt.ptr_ok = 1'b0;
      nxt.sda_oe = 1'b0;
    end
    else if (bus_stop)
    begin
      nxt.st     = S_IDLE;
      nxt.sda_oe = 1'b0;
    end
    else
    begin
      case (cur.st)
        S_IDLE:
        begin
          nxt.sda_oe = 1'b0;
        end
        S_ADDR, S_WBYTE:
        begin
          if (scl_rise)
          begin
            nxt.sh   = {cur.sh[6:0], cur.sda_s};
            nxt.bits = 4'(cur.bits + 4'h1);
          end
          else if (scl_fall && cur.bits == `BYTE_BITS)
          begin
            if (cur.st == S_ADDR)
            begin
              if (hit_primary || hit_second)
              begin
                nxt.rd      = cur.sh[0];
                nxt.sec_hit = hit_second && !hit_primary;
                nxt.sda_oe  = 1'b1;
                nxt.st      = S_ACK;
              end
              else
                nxt.st = S_IDLE;
            end
            else
            begin
              nxt.sda_oe = 1'b1;
              nxt.st     = S_ACK;
              if (!cur.ptr_ok)
              begin
                nxt.ptr    = cur.sh;
                nxt.ptr_ok = 1'b1;
              end
              else
              begin
                case (cur.ptr)
                  `REG_PORT_STEER:
                  begin
                    nxt.steer = cur.sh & `STEER_WR_MASK;
                  end
                  `REG_FREQ_METER:
                  begin
                    nxt.fc_start = 1'b1;
                    nxt.fc_val   = cur.sh;
                  end
                  `REG_FAR_CAPS:
                  begin
                    for (int p = 0; p < 2; p++)
                    begin
                      if (wr_ports[p])
                        nxt.caps[p] = cur.sh & `CAPS_WR_MASK;
                    end
                  end
                  default:
                  begin
                  end
                endcase
                nxt.ptr = 8'(cur.ptr + 8'h01);
              end
            end
          end
        end
        S_ACK:
        begin
          if (scl_fall)
          begin
            nxt.bits = 4'h0;
            if (cur.rd)
            begin
              nxt.sh     = rd_data;
              nxt.ptr    = 8'(cur.ptr + 8'h01);
              nxt.sda_oe = ~rd_data[7];
              nxt.st     = S_RBYTE;
            end
            else
            begin
              nxt.sda_oe = 1'b0;
              nxt.st     = S_WBYTE;
            end
          end
        end
        S_RBYTE:
        begin
          if (scl_rise)
            nxt.bits = 4'(cur.bits + 4'h1);
          else if (scl_fall)
          begin
            if (cur.bits == `BYTE_BITS)
            begin
              nxt.sda_oe = 1'b0;
              nxt.st     = S_RACK;
            end
            else
            begin
              nxt.sh     = {cur.sh[6:0], 1'b0};
              nxt.sda_oe = ~cur.sh[6];
            end
          end
        end
        S_RACK:
        begin
          // a nack from the host ends the read; its stop follows
          if (scl_rise && cur.sda_s)
            nxt.st = S_IDLE;
          else if (scl_fall)
          begin
            nxt.bits   = 4'h0;
            nxt.sh     = rd_data;
            nxt.ptr    = 8'(cur.ptr + 8'h01);
            nxt.sda_oe = ~rd_data[7];
            nxt.st     = S_RBYTE;
          end
        end
        default:
        begin
          nxt.st     = S_IDLE;
          nxt.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cur         <= '0;
      cur.scl_m   <= 1'b1;
      cur.scl_s   <= 1'b1;
      cur.scl_p   <= 1'b1;
      cur.sda_m   <= 1'b1;
      cur.sda_s   <= 1'b1;
      cur.sda_p   <= 1'b1;
      cur.st      <= S_IDLE;
      cur.steer   <= `STEER_RESET;
      cur.caps    <= {`CAPS_RESET, `CAPS_RESET};
      cur.fc_val  <= `FREQ_RESET;
    end
    else
      cur <= nxt;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign sda_o  = cur.sda_o;
  assign sda_oe = cur.sda_oe;
  assign freq_training_request = {cur.caps[1][`BIT_FREQ_TRAIN],
                                  cur.caps[0][`BIT_FREQ_TRAIN]};

endmodule // port_select_freq_counter_regs

// ==== psfc_map.svh ====
// register offsets, field positions, reset values and timing figures for
// the port steering / pixel frequency meter register slice.
// assumes a single 25 MHz clock that is also the oscillator used for timing.
`ifndef PSFC_MAP_SVH
`define PSFC_MAP_SVH

// ************************************************************
// register offsets
// ************************************************************
`define REG_PIN_STATUS   8'h1D
`define REG_PORT_STEER   8'h1E
`define REG_FREQ_METER   8'h1F
`define REG_FAR_CAPS     8'h20

// ************************************************************
// reset values and masks
// ************************************************************
`define STEER_RESET      8'h01
`define STEER_WR_MASK    8'h07
`define CAPS_RESET       8'h00
`define CAPS_WR_MASK     8'hBF
`define CAPS_AUTO_MASK   8'h3F
`define FREQ_RESET       8'h00
`define FREQ_SATURATE    8'hFF

// ************************************************************
// field positions
// ************************************************************
`define BIT_PRIMARY_PICK    0
`define BIT_SECONDARY_PICK  1
`define BIT_SECOND_ADDR     2
`define BIT_FREQ_TRAIN      5
`define BIT_HOLD_CAPS       7

// ************************************************************
// timing
// ************************************************************
`define OSC_PERIOD_NS    40
`define CLK_PERIOD_NS    40
`define OSC_TICK_CYCLES  ((`OSC_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BYTE_BITS        4'h8

`endif

// ==== psfc_pkg.sv ====
// types shared by the register slice and its frequency meter.
// assumes psfc_map.svh supplies the numeric constants.
package psfc_pkg;

  typedef enum logic [2:0]
  {
    S_IDLE,
    S_ADDR,
    S_ACK,
    S_WBYTE,
    S_RBYTE,
    S_RACK
  } i2c_state_e;

  typedef struct packed
  {
    logic             scl_m;
    logic             scl_s;
    logic             scl_p;
    logic             sda_m;
    logic             sda_s;
    logic             sda_p;
    logic             gp_m;
    logic             gp_s;
    logic [6:0]       addr_m;
    logic [6:0]       addr_s;
    i2c_state_e       st;
    logic [3:0]       bits;
    logic [7:0]       sh;
    logic             rd;
    logic             sec_hit;
    logic             ptr_ok;
    logic [7:0]       ptr;
    logic             sda_oe;
    logic             sda_o;
    logic [7:0]       steer;
    logic [1:0][7:0]  caps;
    logic             fc_start;
    logic [7:0]       fc_val;
  } regs_s;

  typedef struct packed
  {
    logic             pclk_m;
    logic             pclk_s;
    logic             pclk_p;
    logic [15:0]      timer;
    logic [7:0]       count;
    logic             busy;
  } meter_s;

endpackage

// ==== meter_if.sv ====
// carrier between the register slice and its pixel frequency meter.
// assumes both ends run on the same clock.
`timescale 1ns/1ps
interface meter_if;
  logic       start;
  logic [7:0] interval;
  logic [7:0] count;
  logic       busy;

  modport ctrl (output start, output interval, input count, input busy);
  modport meter (input start, input interval, output count, output busy);
endinterface

// ==== pixel_freq_meter.sv ====
// counts pixel clock edges over a window timed in oscillator periods.
// assumes clk is the oscillator and the pixel clock pin is asynchronous.
`timescale 1ns/1ps
`include "psfc_map.svh"
module pixel_freq_meter
  import psfc_pkg::*;
(
  input  wire logic  clk,        // oscillator clock
  input  wire logic  nrst,       // async reset, active low
  input  wire logic  pclk_pin,   // raw pixel clock pin
  meter_if.meter     mtr         // start / count exchange
);

  meter_s cur;
  meter_s nxt;
  logic   pclk_edge;

  // edges are found after a two-stage synchroniser, so only pixel clocks
  // below half the oscillator rate are counted faithfully
  assign pclk_edge = cur.pclk_s & ~cur.pclk_p;

  always_comb
  begin
    nxt        = cur;
    nxt.pclk_m = pclk_pin;
    nxt.pclk_s = cur.pclk_m;
    nxt.pclk_p = cur.pclk_s;
    if (mtr.start)
    begin
      nxt.count = `FREQ_RESET;
      nxt.timer = 16'(mtr.interval * `OSC_TICK_CYCLES);
      nxt.busy  = (mtr.interval != 8'h00);
    end
    else if (cur.busy)
    begin
      if (pclk_edge && cur.count != `FREQ_SATURATE)
        nxt.count = 8'(cur.count + 8'h01);
      nxt.timer = 16'(cur.timer - 16'h0001);
      if (cur.timer == 16'h0001)
        nxt.busy = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cur <= '0;
    else
      cur <= nxt;
  end

  assign mtr.count = cur.count;
  assign mtr.busy  = cur.busy;

endmodule // pixel_freq_meter

// ==== i2c_host_model.sv ====
// i2c host model: bit-banged open-drain master for the register slice.
// assumes the bench resolves sda from both enables with a pull-up.
`timescale 1ns/1ps
module i2c_host_model
(
  input  wire logic clk,     // bench clock, paces the bus
  input  wire logic sda,     // resolved data wire
  output logic      scl,     // clock line, high when idle
  output logic      host_oe  // high pulls sda low
);
  // ************************************************************
  // bus primitives
  // ************************************************************
  initial
  begin
    scl = 1'b1;
    host_oe = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  // half periods of 10 clk keep clear of the 8 clk minimum
  task automatic start();
    host_oe = 1'b0;
    wt(5);
    scl = 1'b1;
    wt(10);
    host_oe = 1'b1;
    wt(10);
    scl = 1'b0;
    wt(5);
  endtask

  task automatic stop();
    host_oe = 1'b1;
    wt(5);
    scl = 1'b1;
    wt(10);
    host_oe = 1'b0;
    wt(10);
  endtask

  // data moves 5 clk after scl falls, well past the device's 2.5 clk hold
  task automatic bitx(input logic b, output logic r);
    host_oe = !b;
    wt(5);
    scl = 1'b1;
    wt(10);
    r = sda;
    scl = 1'b0;
    wt(5);
  endtask

  task automatic byte_x(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bitx(d[i], r);
      q[i] = r;
    end
    bitx(1'b1, r);
    ack = !r;
  endtask

  // ************************************************************
  // register transfers
  // ************************************************************
  task automatic reg_wr(input logic [6:0] a, input logic [7:0] off, input logic [7:0] d,
                        output logic ok);
    logic [7:0] q;
    logic       k1, k2, k3;
    start();
    byte_x({a, 1'b0}, q, k1);
    byte_x(off, q, k2);
    byte_x(d, q, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask

  // single-byte read: the host nacks the data byte to end it
  task automatic reg_rd(input logic [6:0] a, input logic [7:0] off, output logic [7:0] d,
                        output logic ok);
    logic [7:0] q;
    logic       k1, k2, k3, k4;
    start();
    byte_x({a, 1'b0}, q, k1);
    byte_x(off, q, k2);
    start();
    byte_x({a, 1'b1}, q, k3);
    byte_x(8'hFF, d, k4);
    stop();
    ok = k1 & k2 & k3;
  endtask
endmodule // i2c_host_model

// ==== port_select_freq_counter_regs_chk.sv ====
// checker for the register slice: watches only the top-level pins.
// assumes one clock domain and a pull-up on sda outside the device.
`timescale 1ns/1ps
module psfc_regs_chk
(
  input wire logic        clk,                   // clock
  input wire logic        nrst,                  // reset, active low
  input wire logic        scl_i,                 // i2c clock
  input wire logic        sda_i,                 // i2c data
  input wire logic        sda_o,                 // drive value
  input wire logic        sda_oe,                // drive enable
  input wire logic [6:0]  own_bus_address,       // primary address
  input wire logic        gp_pin_eight,          // pin eight
  input wire logic        pin_input_mode,        // pin eight mode
  input wire logic        pixel_clk_pin,         // pixel clock
  input wire logic [1:0]  far_lock,              // far lock
  input wire logic [15:0] far_caps,              // back-channel caps
  input wire logic [1:0]  freq_training_request  // training request
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // ************************************************************
  // helpers
  // ************************************************************
  // quiet holds until the host first pulls scl low, so no write can have landed
  logic       quiet_ff;
  logic [3:0] low_ff;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      quiet_ff <= 1'b1;
      low_ff <= 4'h0;
    end
    else
    begin
      quiet_ff <= quiet_ff & scl_i;
      low_ff <= scl_i ? 4'h0 : low_ff + 4'h1;
    end
  end

  sequence s_steady(p);
    (quiet_ff && far_lock[p] && $stable(far_caps)) [*2];
  endsequence

  // ************************************************************
  // assertions
  // ************************************************************
  a_train_load0: assert property (s_steady(0) |-> freq_training_request[0] == far_caps[5])
    else $error("port 0 training flag missed back-channel value");
  a_train_load1: assert property (s_steady(1) |-> freq_training_request[1] == far_caps[13])
    else $error("port 1 training flag missed back-channel value");
  a_train_still: assert property (quiet_ff && far_lock == 2'b00 |=> $stable(freq_training_request))
    else $error("training flag moved without lock");
  a_idle_quiet: assert property (quiet_ff |-> !sda_oe)
    else $error("sda driven before any transfer");
  a_low_only: assert property (sda_oe |-> !sda_o)
    else $error("sda driven high");
  a_ack_delay: assert property ($rose(sda_oe) |-> !scl_i && low_ff inside {[2:5]})
    else $error("sda drive began off the scl low slot");
  a_drive_span: assert property ($fell(sda_oe) |-> !scl_i && low_ff inside {[2:5]})
    else $error("sda released off the scl low slot");
  a_rst_release: assert property ($rose(nrst) |-> !sda_oe && freq_training_request == 2'b00)
    else $error("outputs not idle after reset");
endmodule // psfc_regs_chk

bind port_select_freq_counter_regs psfc_regs_chk psfc_regs_chk_inst
(
  .clk(clk), .nrst(nrst), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .own_bus_address(own_bus_address), .gp_pin_eight(gp_pin_eight),
  .pin_input_mode(pin_input_mode), .pixel_clk_pin(pixel_clk_pin), .far_lock(far_lock),
  .far_caps(far_caps), .freq_training_request(freq_training_request)
);

// ==== tb_port_select_freq_counter_regs.sv ====
// self-checking bench for the register slice, driven through an i2c host model.
// assumes the design files, psfc_map.svh and the host model are compiled first.
`timescale 1ns/1ps
`include "psfc_map.svh"
module tb_port_select_freq_counter_regs;
  logic        clk, nrst, scl, host_oe, sda_w, sda_o, sda_oe, gp, pim, pclk, rnd_en, ok;
  logic [6:0]  own;
  logic [1:0]  lock, ftr;
  logic [15:0] caps;
  logic [31:0] seed;
  logic [7:0]  q, v0, v1, v2, n;
  int          fail_count, num_checks, cyc, lo;

  assign sda_w = !(sda_oe | host_oe);

  port_select_freq_counter_regs port_select_freq_counter_regs_inst
  (
    .clk(clk), .nrst(nrst), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .own_bus_address(own), .gp_pin_eight(gp), .pin_input_mode(pim), .pixel_clk_pin(pclk),
    .far_lock(lock), .far_caps(caps), .freq_training_request(ftr)
  );
  i2c_host_model i2c_host_model_inst (.clk(clk), .sda(sda_w), .scl(scl), .host_oe(host_oe));

  // ************************************************************
  // clocks, stimulus, helpers
  // ************************************************************
  always #20 clk = ~clk;
  // 162 ns pixel period: under the sync limit and drifting against clk
  always #81 pclk = ~pclk;

  always @(negedge clk)
  begin
    if (rnd_en)
    begin
      caps <= 16'(xs());
      lock <= 2'(xs());
    end
  end

  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 60000)
    begin
      fail_count = fail_count + 1;
      results();
    end
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // bit 6 of the caps register is never stored
  function automatic logic [7:0] cap_exp(input logic [7:0] v);
    return v & `CAPS_WR_MASK;
  endfunction

  function automatic int edges(input logic [7:0] w);
    return int'(w) * 40 / 162;
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      fail_count = fail_count + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] off, input logic [7:0] d);
    i2c_host_model_inst.reg_wr(a, off, d, ok);
    chk({7'h0, ok}, 8'h01);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] off);
    i2c_host_model_inst.reg_rd(a, off, q, ok);
    chk({7'h0, ok}, 8'h01);
  endtask

  task automatic results();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    seed = 32'h15C6;
    clk = 1'b0;
    nrst = 1'b0;
    gp = 1'b0;
    pim = 1'b0;
    pclk = 1'b0;
    rnd_en = 1'b0;
    lock = 2'h0;
    caps = 16'h0;
    fail_count = 0;
    num_checks = 0;
    cyc = 0;
    own = 7'(xs() % 125) + 7'h01;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    rnd_en = 1'b1;
    repeat (60) @(negedge clk);
    rnd_en = 1'b0;
    // let the random process see rnd_en low before caps and lock are driven here
    @(negedge clk);
    caps = 16'(xs());
    lock = 2'b11;
    repeat (3) @(negedge clk);
    chk({6'h0, ftr}, {6'h0, caps[13], caps[5]});
    lock = 2'b00;
    caps = ~caps;
    repeat (3) @(negedge clk);
    chk({6'h0, ftr}, {6'h0, ~caps[13], ~caps[5]});
    rnd_en = 1'b1;
    rd(own, `REG_PORT_STEER);
    chk(q, `STEER_RESET);
    rd(own, `REG_FREQ_METER);
    chk(q, `FREQ_RESET);
    wr(own, `REG_PORT_STEER, 8'hF9);
    rd(own, `REG_PORT_STEER);
    chk(q, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      {gp, pim} = 2'(i);
      rd(own, `REG_PIN_STATUS);
      chk(q, {7'h0, gp & pim});
    end
    i2c_host_model_inst.reg_rd(own + 7'h01, `REG_PORT_STEER, q, ok);
    chk({7'h0, ok}, 8'h00);
    v0 = 8'(xs()) | 8'h80;
    v1 = 8'(xs()) | 8'h80;
    v2 = 8'(xs()) | 8'h80;
    wr(own, `REG_PORT_STEER, 8'h03);
    wr(own, `REG_FAR_CAPS, v0);
    wr(own, `REG_PORT_STEER, 8'h02);
    wr(own, `REG_FAR_CAPS, v1);
    rd(own, `REG_FAR_CAPS);
    chk(q, cap_exp(v1));
    chk({6'h0, ftr}, {6'h0, v1[5], v0[5]});
    wr(own, `REG_PORT_STEER, 8'h01);
    rd(own, `REG_FAR_CAPS);
    chk(q, cap_exp(v0));
    wr(own, `REG_PORT_STEER, 8'h03);
    rd(own, `REG_FAR_CAPS);
    chk(q, cap_exp(v1));
    wr(own, `REG_PORT_STEER, 8'h07);
    rd(own, `REG_FAR_CAPS);
    chk(q, cap_exp(v0));
    wr(own + 7'h01, `REG_FAR_CAPS, v2);
    rd(own + 7'h01, `REG_FAR_CAPS);
    chk(q, cap_exp(v2));
    rd(own, `REG_FAR_CAPS);
    chk(q, cap_exp(v0));
    rd(own + 7'h01, `REG_PORT_STEER);
    chk(q, 8'h07);
    // a read takes far longer than the widest window, so it always sees a finished count
    for (int i = 0; i < 6; i++)
    begin
      n = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'(xs());
      wr(own, `REG_FREQ_METER, n);
      rd(own, `REG_FREQ_METER);
      lo = edges(n);
      chk({7'h0, (int'(q) >= lo - 1) && (int'(q) <= lo + 1)}, 8'h01);
    end
    wr(own, `REG_FREQ_METER, 8'h00);
    rd(own, `REG_FREQ_METER);
    chk(q, 8'h00);
    results();
  end
endmodule // tb_port_select_freq_counter_regs
